/* File: rtl/cpm_pkg.sv */
package cpm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int unsigned T_PRESENT_MS = 200;
  localparam int unsigned T_ABSENT_MS = 3000;
  localparam int unsigned T_PW_IDLE_MS = 15000;
  localparam int unsigned T_PW_DCHG_MS = 2000;
  localparam int unsigned T_DCHG_L_MS = 500;
  localparam int unsigned T_DCHG_S_MS = 100;
  localparam int unsigned T_BC_DCHG_MS = 100;
  localparam int unsigned T_1V2_MS = 100;
  localparam int unsigned T_DIV2_TEST_MS = 1000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_OFF = 8'h00;
  localparam logic [7:0] REG_STATUS_OFF = 8'h04;
  localparam logic CTRL_HID_HOLD_RST = 1'b0;
  localparam int unsigned CTRL_HID_HOLD_BIT = 0;
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_BIAS_LSB = 4;
  localparam int unsigned ST_LIMIT_LSB = 8;
  localparam int unsigned ST_SWITCH_BIT = 12;
  localparam int unsigned ST_DCHG_BIT = 13;
  localparam int unsigned ST_PRESENT_BIT = 14;
  localparam int unsigned ST_AUTO_LSB = 16;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MD_DISCH = 3'h0, MD_AUTO = 3'h1, MD_STANDARD_PORT_MODE_ONE = 3'h2, MD_SHORT = 3'h3,
    MD_DIV1 = 3'h4, MD_STANDARD_PORT_MODE_TWO = 3'h5, MD_CDP = 3'h6
  } cpm_mode_t;

  typedef enum logic [2:0] {
    BI_NONE = 3'h0, BI_DIV1 = 3'h1, BI_DIV2 = 3'h2, BI_1V2 = 3'h3,
    BI_SHORT = 3'h4
  } cpm_bias_t;

  typedef enum logic [1:0] {
    LIM_LO = 2'h0, LIM_HI = 2'h1, LIM_PW = 2'h2, LIM_NONE = 2'h3
  } cpm_lim_t;

  typedef enum logic [1:0] {
    LD_OFF = 2'h0, LD_PW = 2'h1, LD_NPW = 2'h2, LD_CDP = 2'h3
  } cpm_ld_t;

  typedef enum logic [2:0] {
    AU_DIV1 = 3'h0, AU_DIV2_TEST = 3'h1, AU_DIV2 = 3'h2,
    AU_BC_DCHG = 3'h3, AU_1V2 = 3'h4, AU_BC12 = 3'h5
  } cpm_auto_t;

  typedef enum logic [1:0] {
    PW_HIGH = 2'h0, PW_LOW = 2'h1, PW_DCHG = 2'h2
  } cpm_pw_t;

  // Select code is {select_a, select_b, select_c}.
  function automatic cpm_mode_t cpm_decode(input logic [2:0] sel,
                                           input logic lim);
    cpm_mode_t m;
    m = MD_DISCH;
    unique case (sel)
      3'h0: m = MD_DISCH;
      3'h1, 3'h3: m = MD_AUTO;
      3'h2, 3'h6: m = MD_STANDARD_PORT_MODE_ONE;
      3'h4: m = MD_SHORT;
      3'h5: m = MD_DIV1;
      3'h7: m = lim ? MD_CDP : MD_STANDARD_PORT_MODE_TWO;
    endcase
    return m;
  endfunction : cpm_decode

  function automatic cpm_ld_t cpm_ld_decode(input logic [2:0] sel,
                                            input logic lim);
    cpm_ld_t l;
    l = LD_OFF;
    if (lim) begin
      if (sel == 3'h1) l = LD_PW;
      else if (sel == 3'h3) l = LD_NPW;
      else if (sel == 3'h7) l = LD_CDP;
    end
    return l;
  endfunction : cpm_ld_decode

endpackage : cpm_pkg

/* File: rtl/cpm_ld_if.sv */
`timescale 1ns/1ns
interface cpm_ld_if;
  import cpm_pkg::*;
  cpm_ld_t ld_mode;
  logic over_lo60;
  logic under_lo10;
  logic under_45;
  logic at_limit;
  logic primary_det;
  logic present;
  logic pw_internal;
  logic pw_dchg;
  modport ctl (output ld_mode, over_lo60, under_lo10, under_45, at_limit,
               primary_det, input present, pw_internal, pw_dchg);
  modport det (input ld_mode, over_lo60, under_lo10, under_45, at_limit,
               primary_det, output present, pw_internal, pw_dchg);
endinterface : cpm_ld_if

/* File: rtl/cpm_load_detect.sv */
`timescale 1ns/1ns
module cpm_load_detect
  import cpm_pkg::*;
#(
  parameter int unsigned PRES_CYC = T_PRESENT_MS * CYC_PER_MS,
  parameter int unsigned ABS_CYC = T_ABSENT_MS * CYC_PER_MS,
  parameter int unsigned PW_IDLE_CYC = T_PW_IDLE_MS * CYC_PER_MS,
  parameter int unsigned PW_DCHG_CYC = T_PW_DCHG_MS * CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  cpm_ld_if.det ld
);

  typedef struct packed {
    logic present;
    cpm_pw_t pw_st;
    logic [31:0] cnt;
  } cpm_ld_st_t;

  cpm_ld_st_t s_r;
  cpm_ld_st_t s_nxt;

  // ----------------------------------------------------------------
  // Qualification timers
  // ----------------------------------------------------------------
  // One shared counter restarts whenever its condition drops.
  always_comb begin
    s_nxt = s_r;
    s_nxt.cnt = 32'h0;
    unique case (ld.ld_mode)
      LD_OFF: begin
        s_nxt.present = 1'b0;
        s_nxt.pw_st = PW_HIGH;
      end
      LD_NPW, LD_CDP: begin
        s_nxt.pw_st = PW_HIGH;
        if (!s_r.present && ld.over_lo60) begin
          s_nxt.cnt = s_r.cnt + 32'h1;
          if (s_r.cnt == PRES_CYC - 1) begin
            s_nxt.present = 1'b1;
            s_nxt.cnt = 32'h0;
          end
        end else if (s_r.present && ld.under_lo10) begin
          s_nxt.cnt = s_r.cnt + 32'h1;
          if (s_r.cnt == ABS_CYC - 1) begin
            s_nxt.present = 1'b0;
            s_nxt.cnt = 32'h0;
          end
        end
        if (ld.ld_mode == LD_CDP && ld.primary_det) begin
          s_nxt.present = 1'b1;
        end
      end
      LD_PW: begin
        unique case (s_r.pw_st)
          PW_HIGH: begin
            if (ld.under_45) begin
              s_nxt.cnt = s_r.cnt + 32'h1;
              if (s_r.cnt == PW_IDLE_CYC - 1) begin
                s_nxt.pw_st = PW_LOW;
                s_nxt.present = 1'b0;
                s_nxt.cnt = 32'h0;
              end
            end
          end
          PW_LOW: begin
            if (ld.at_limit) begin
              s_nxt.pw_st = PW_DCHG;
              s_nxt.present = 1'b1;
            end
          end
          PW_DCHG: begin
            s_nxt.cnt = s_r.cnt + 32'h1;
            if (s_r.cnt == PW_DCHG_CYC - 1) begin
              s_nxt.pw_st = PW_HIGH;
              s_nxt.cnt = 32'h0;
            end
          end
          default: s_nxt.pw_st = PW_HIGH;
        endcase
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{present: 1'b0, pw_st: PW_HIGH, cnt: 32'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ld.present = s_r.present;
  assign ld.pw_internal = (s_r.pw_st == PW_LOW);
  assign ld.pw_dchg = (s_r.pw_st == PW_DCHG);

endmodule : cpm_load_detect

/* File: rtl/cpm_charge_port.sv */
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
// Function
// - Auto: divider one, shorted attach, discharge, 1.2V, BC1.2
// - BC1.2 held until data line released
// - Divider-one device keeps divider one scheme
// - Over 750 mA tries divider two, keeps or reverts
// - Data switches close only CDP/SDP with enable
// - Switches open: enable low, code 000, DCP
// - CDP handshaking keeps data switches closed
// - Switches open during any output discharge
// - Follow select pins unless HID hold active
// - Code 000 discharge; 010/110 standard port one
// - Codes 001/011 auto, high limit, load detect with limit pin high
// - Code 100 forced shorted, chosen limit, no load
// - Code 101 forced divider one, chosen limit
// - Code 1111 CDP, high limit, load detect
// - Code 1110 low limit, no discharge to CDP
// - Power-wake auto swaps internal and high limit
// - Load present after above low+60 for 200 ms
// - Load absent after below low+10 for 3 s
// - Below 45 mA for 15 s: internal limit
// - Power wake limit hit: present, 2 s discharge
module cpm_charge_port
  import cpm_pkg::*;
#(
  parameter int unsigned DCHG_L_CYC = T_DCHG_L_MS * CYC_PER_MS,
  parameter int unsigned DCHG_S_CYC = T_DCHG_S_MS * CYC_PER_MS,
  parameter int unsigned BC_DCHG_CYC = T_BC_DCHG_MS * CYC_PER_MS,
  parameter int unsigned V1P2_CYC = T_1V2_MS * CYC_PER_MS,
  parameter int unsigned DIV2_TEST_CYC = T_DIV2_TEST_MS * CYC_PER_MS,
  parameter int unsigned PRES_CYC = T_PRESENT_MS * CYC_PER_MS,
  parameter int unsigned ABS_CYC = T_ABSENT_MS * CYC_PER_MS,
  parameter int unsigned PW_IDLE_CYC = T_PW_IDLE_MS * CYC_PER_MS,
  parameter int unsigned PW_DCHG_CYC = T_PW_DCHG_MS * CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic charge_mode_select_a,
  input wire logic charge_mode_select_b,
  input wire logic charge_mode_select_c,
  input wire logic limit_choice_pin,
  input wire logic port_enable,
  input wire logic shorted_dev_attach,
  input wire logic data_line_released,
  input wire logic curr_over_750ma,
  input wire logic curr_over_lo_plus60,
  input wire logic curr_under_lo_plus10,
  input wire logic curr_under_45ma,
  input wire logic at_internal_limit,
  input wire logic bc12_primary_det,
  output logic data_switch_on,
  output logic out_discharge,
  output logic [2:0] bias_scheme,
  output logic [1:0] current_limit_sel,
  output logic load_present_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  localparam int unsigned PIN_W = 13;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic hid_hold;
    cpm_mode_t mode;
    cpm_auto_t auto_st;
    logic [31:0] auto_cnt;
    logic [31:0] dchg_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic data_sw;
    logic out_dchg;
    cpm_bias_t bias;
    cpm_lim_t limit;
    logic present_n;
    logic [31:0] rdata;
  } cpm_top_st_t;

  cpm_top_st_t s_r;
  cpm_top_st_t s_nxt;
  cpm_ld_if ld_bus ();

  // ----------------------------------------------------------------
  // Synchronised pin view
  // ----------------------------------------------------------------
  logic [2:0] sel;
  logic lim_pin;
  logic en_pin;
  logic shorted_att;
  logic released;
  logic over750;
  cpm_mode_t target;
  logic [31:0] status_word;
  logic bus_take;
  logic any_dchg;

  assign sel = s_r.sync2[12:10];
  assign lim_pin = s_r.sync2[9];
  assign en_pin = s_r.sync2[8];
  assign shorted_att = s_r.sync2[7];
  assign released = s_r.sync2[6];
  assign over750 = s_r.sync2[5];
  assign target = cpm_decode(sel, lim_pin);

  assign ld_bus.ld_mode = (s_r.mode == target) ?
                          cpm_ld_decode(sel, lim_pin) : LD_OFF;
  assign ld_bus.over_lo60 = s_r.sync2[4];
  assign ld_bus.under_lo10 = s_r.sync2[3];
  assign ld_bus.under_45 = s_r.sync2[2];
  assign ld_bus.at_limit = s_r.sync2[1];
  assign ld_bus.primary_det = s_r.sync2[0];

  cpm_load_detect #(
    .PRES_CYC(PRES_CYC),
    .ABS_CYC(ABS_CYC),
    .PW_IDLE_CYC(PW_IDLE_CYC),
    .PW_DCHG_CYC(PW_DCHG_CYC)
  ) u_ld (
    .core_clk(core_clk),
    .rst(rst),
    .ld(ld_bus.det)
  );

  // ----------------------------------------------------------------
  // Status and bus decode
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 32'h0;
    status_word[ST_MODE_LSB +: 3] = s_r.mode;
    status_word[ST_BIAS_LSB +: 3] = s_r.bias;
    status_word[ST_LIMIT_LSB +: 2] = s_r.limit;
    status_word[ST_SWITCH_BIT] = s_r.data_sw;
    status_word[ST_DCHG_BIT] = s_r.out_dchg;
    status_word[ST_PRESENT_BIT] = ~s_r.present_n;
    status_word[ST_AUTO_LSB +: 3] = s_r.auto_st;
  end

  assign bus_take = hsel && hready && htrans[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = {charge_mode_select_a, charge_mode_select_b,
                   charge_mode_select_c, limit_choice_pin, port_enable,
                   shorted_dev_attach, data_line_released, curr_over_750ma,
                   curr_over_lo_plus60, curr_under_lo_plus10,
                   curr_under_45ma, at_internal_limit, bc12_primary_det};
    s_nxt.sync2 = s_r.sync1;

    // Writes land in the data phase.
    s_nxt.wr_pend = 1'b0;
    if (s_r.wr_pend && s_r.wr_addr == REG_CTRL_OFF) begin
      s_nxt.hid_hold = hwdata[CTRL_HID_HOLD_BIT];
    end
    if (bus_take) begin
      s_nxt.wr_pend = hwrite && hsize == HSIZE_WORD &&
                      haddr[31:8] == 24'h0;
      s_nxt.wr_addr = haddr[7:0];
      s_nxt.rdata = 32'h0;
      if (!hwrite && haddr[31:8] == 24'h0) begin
        if (haddr[7:0] == REG_CTRL_OFF) begin
          s_nxt.rdata[CTRL_HID_HOLD_BIT] = s_r.hid_hold;
        end else if (haddr[7:0] == REG_STATUS_OFF) begin
          s_nxt.rdata = status_word;
        end
      end
    end

    // A reported HID freezes the mode.
    if (s_r.dchg_cnt != 32'h0) begin
      s_nxt.dchg_cnt = s_r.dchg_cnt - 32'h1;
    end
    if (target != s_r.mode && !s_r.hid_hold) begin
      s_nxt.mode = target;
      s_nxt.auto_st = AU_DIV1;
      s_nxt.auto_cnt = 32'h0;
      if ((s_r.mode == MD_STANDARD_PORT_MODE_TWO && target == MD_CDP) ||
          (s_r.mode == MD_CDP && target == MD_STANDARD_PORT_MODE_TWO)) begin
        s_nxt.dchg_cnt = s_r.dchg_cnt;
      end else if (target == MD_AUTO) begin
        s_nxt.dchg_cnt = DCHG_L_CYC;
      end else if (target != MD_DISCH) begin
        s_nxt.dchg_cnt = DCHG_S_CYC;
      end
    end else if (s_r.mode == MD_AUTO && s_r.dchg_cnt == 32'h0) begin
      s_nxt.auto_cnt = s_r.auto_cnt + 32'h1;
      unique case (s_r.auto_st)
        AU_DIV1: begin
          s_nxt.auto_cnt = 32'h0;
          if (shorted_att) begin
            s_nxt.auto_st = AU_BC_DCHG;
          end else if (over750) begin
            s_nxt.auto_st = AU_DIV2_TEST;
          end else begin
            s_nxt.auto_st = AU_DIV1;
          end
        end
        AU_DIV2_TEST: begin
          if (s_r.auto_cnt == DIV2_TEST_CYC - 1) begin
            s_nxt.auto_cnt = 32'h0;
            s_nxt.auto_st = over750 ? AU_DIV2 : AU_DIV1;
          end
        end
        AU_DIV2: s_nxt.auto_cnt = 32'h0;
        AU_BC_DCHG: begin
          if (s_r.auto_cnt == BC_DCHG_CYC - 1) begin
            s_nxt.auto_cnt = 32'h0;
            s_nxt.auto_st = AU_1V2;
          end
        end
        AU_1V2: begin
          if (s_r.auto_cnt == V1P2_CYC - 1) begin
            s_nxt.auto_cnt = 32'h0;
            s_nxt.auto_st = AU_BC12;
          end
        end
        AU_BC12: begin
          s_nxt.auto_cnt = 32'h0;
          if (released) begin
            s_nxt.auto_st = AU_DIV1;
          end
        end
        default: s_nxt.auto_st = AU_DIV1;
      endcase
    end

    any_dchg = (s_nxt.mode == MD_DISCH) || (s_nxt.dchg_cnt != 32'h0) ||
               (s_nxt.mode == MD_AUTO && s_nxt.auto_st == AU_BC_DCHG) ||
               ld_bus.pw_dchg;
    s_nxt.out_dchg = any_dchg;
    // Current limiting never opens the switches.
    s_nxt.data_sw = en_pin && !any_dchg &&
                    (s_nxt.mode == MD_STANDARD_PORT_MODE_ONE || s_nxt.mode == MD_STANDARD_PORT_MODE_TWO ||
                     s_nxt.mode == MD_CDP);
    s_nxt.present_n = ~ld_bus.present;
    unique case (s_nxt.mode)
      MD_DISCH: begin
        s_nxt.bias = BI_NONE;
        s_nxt.limit = LIM_NONE;
        s_nxt.present_n = 1'b1;
      end
      MD_AUTO: begin
        unique case (s_nxt.auto_st)
          AU_DIV2_TEST, AU_DIV2: s_nxt.bias = BI_DIV2;
          AU_1V2: s_nxt.bias = BI_1V2;
          AU_BC12: s_nxt.bias = BI_SHORT;
          default: s_nxt.bias = BI_DIV1;
        endcase
        s_nxt.limit = ld_bus.pw_internal ? LIM_PW : LIM_HI;
      end
      MD_SHORT: begin
        s_nxt.bias = BI_SHORT;
        s_nxt.limit = lim_pin ? LIM_HI : LIM_LO;
        s_nxt.present_n = 1'b1;
      end
      MD_DIV1: begin
        s_nxt.bias = BI_DIV1;
        s_nxt.limit = lim_pin ? LIM_HI : LIM_LO;
        s_nxt.present_n = 1'b1;
      end
      MD_STANDARD_PORT_MODE_ONE: begin
        s_nxt.bias = BI_NONE;
        s_nxt.limit = lim_pin ? LIM_HI : LIM_LO;
        s_nxt.present_n = 1'b1;
      end
      MD_STANDARD_PORT_MODE_TWO: begin
        s_nxt.bias = BI_NONE;
        s_nxt.limit = LIM_LO;
        s_nxt.present_n = 1'b1;
      end
      MD_CDP: begin
        s_nxt.bias = BI_NONE;
        s_nxt.limit = LIM_HI;
      end
      default: begin
        s_nxt.bias = BI_NONE;
        s_nxt.limit = LIM_NONE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset mirrors power-on: output held in discharge, switches open.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{sync1: '0, sync2: '0, hid_hold: CTRL_HID_HOLD_RST,
               mode: MD_DISCH, auto_st: AU_DIV1, auto_cnt: 32'h0,
               dchg_cnt: 32'h0, wr_pend: 1'b0, wr_addr: 8'h00,
               data_sw: 1'b0, out_dchg: 1'b1, bias: BI_NONE,
               limit: LIM_NONE, present_n: 1'b1, rdata: 32'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign data_switch_on = s_r.data_sw;
  assign out_discharge = s_r.out_dchg;
  assign bias_scheme = s_r.bias;
  assign current_limit_sel = s_r.limit;
  assign load_present_n = s_r.present_n;
  assign hrdata = s_r.rdata;

endmodule : cpm_charge_port

/* File: tb/cpm_dev_model.sv */
`timescale 1ns/1ns
module cpm_dev_model
  import cpm_pkg::*;
#(
  parameter int LO_MA = 12'h12C
) (
  input wire logic [1:0] dev_kind,
  input wire logic [11:0] load_ma,
  input wire logic [1:0] current_limit_sel,
  output logic shorted_dev_attach,
  output logic data_line_released,
  output logic curr_over_750ma,
  output logic curr_over_lo_plus60,
  output logic curr_under_lo_plus10,
  output logic curr_under_45ma,
  output logic at_internal_limit,
  output logic bc12_primary_det
);
  // ----------------------------------------------------------------
  // Attached device
  // ----------------------------------------------------------------
  // Kind 1 shorts the data lines, kind 3 runs primary detection.
  assign shorted_dev_attach = dev_kind == 2'h1;
  assign data_line_released = dev_kind != 2'h1;
  assign bc12_primary_det = dev_kind == 2'h3;
  assign curr_over_750ma = load_ma > 12'h2EE;
  assign curr_over_lo_plus60 = load_ma > LO_MA + 12'h03C;
  assign curr_under_lo_plus10 = load_ma < LO_MA + 12'h00A;
  assign curr_under_45ma = load_ma < 12'h02D;
  // The internal limit trips only while applied.
  assign at_internal_limit = load_ma > 12'h037 &&
                             current_limit_sel == LIM_PW;
endmodule : cpm_dev_model

/* File: tb/cpm_charge_port_sva.sv */
`timescale 1ns/1ns
module cpm_charge_port_sva
  import cpm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic charge_mode_select_a,
  input wire logic charge_mode_select_b,
  input wire logic charge_mode_select_c,
  input wire logic limit_choice_pin,
  input wire logic port_enable,
  input wire logic data_switch_on,
  input wire logic out_discharge,
  input wire logic [2:0] bias_scheme,
  input wire logic [1:0] current_limit_sel,
  input wire logic load_present_n
);
  logic [2:0] sel;
  logic lim;
  assign sel = {charge_mode_select_a, charge_mode_select_b,
                charge_mode_select_c};
  assign lim = limit_choice_pin;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Settled pins
  // ----------------------------------------------------------------
  // A code is judged once stable and out of discharge.
  sequence s_held;
    $stable({sel, lim, port_enable}) [*5] ##0 !out_discharge;
  endsequence
  property p_sw_dchg;
    out_discharge |-> !data_switch_on;
  endproperty
  a_sw_dchg: assert property (p_sw_dchg)
    else $error("data switch closed during discharge");
  property p_sw_en;
    !port_enable [*5] |-> !data_switch_on;
  endproperty
  a_sw_en: assert property (p_sw_en)
    else $error("data switch closed while disabled");
  property p_disch;
    (sel == 3'h0) [*5] |-> out_discharge && load_present_n;
  endproperty
  a_disch: assert property (p_disch)
    else $error("code zero without discharge");
  property p_short;
    s_held ##0 sel == 3'h4 |-> bias_scheme == BI_SHORT &&
      load_present_n && current_limit_sel == {1'b0, lim};
  endproperty
  a_short: assert property (p_short)
    else $error("forced shorted mode wrong");
  property p_div1;
    s_held ##0 sel == 3'h5 |-> bias_scheme == BI_DIV1 &&
      load_present_n && current_limit_sel == {1'b0, lim};
  endproperty
  a_div1: assert property (p_div1)
    else $error("forced divider mode wrong");
  property p_auto;
    s_held ##0 !sel[2] && sel[0] |-> !data_switch_on &&
      (current_limit_sel == LIM_HI ||
       sel == 3'h1 && lim && current_limit_sel == LIM_PW);
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto mode wrong");
  property p_cdp;
    s_held ##0 sel == 3'h7 |-> data_switch_on == port_enable &&
      current_limit_sel == (lim ? LIM_HI : LIM_LO);
  endproperty
  a_cdp: assert property (p_cdp)
    else $error("code seven wrong");
  property p_swap;
    (sel == 3'h7) [*5] ##0 $changed(lim) && !out_discharge
      |-> !out_discharge [*8];
  endproperty
  a_swap: assert property (p_swap)
    else $error("discharge on 1110/1111 swap");
  property p_bc;
    $changed(bias_scheme) && bias_scheme == BI_SHORT && !sel[2] && sel[0]
      |-> $past(bias_scheme) == BI_1V2;
  endproperty
  a_bc: assert property (p_bc)
    else $error("shorted scheme not preceded by 1.2 V");
endmodule : cpm_charge_port_sva

bind cpm_charge_port cpm_charge_port_sva cpm_charge_port_sva_i (
  .core_clk(core_clk), .rst(rst),
  .charge_mode_select_a(charge_mode_select_a),
  .charge_mode_select_b(charge_mode_select_b),
  .charge_mode_select_c(charge_mode_select_c),
  .limit_choice_pin(limit_choice_pin), .port_enable(port_enable),
  .data_switch_on(data_switch_on), .out_discharge(out_discharge),
  .bias_scheme(bias_scheme), .current_limit_sel(current_limit_sel),
  .load_present_n(load_present_n));

/* File: tb/cpm_charge_port_tb.sv */
`timescale 1ns/1ns
module cpm_charge_port_tb;
  import cpm_pkg::*;
  localparam int PRES = 24;
  localparam int ABS = 32;
  localparam int PWI = 40;
  localparam int PWD = 12;
  localparam logic [2:0] MT [8] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h3, 3'h4,
                                    3'h2, 3'h5};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] code = 4'h0;
  logic en = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [11:0] load = 12'h064;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r;
  logic [2:0] bias;
  logic [1:0] lim;
  logic sda, rel, o750, o60, u10, u45, atl, prim;
  logic sw, dchg, pres_n, hreadyout;
  int err_total = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  cpm_charge_port #(.DCHG_L_CYC(20), .DCHG_S_CYC(10), .BC_DCHG_CYC(8),
    .V1P2_CYC(8), .DIV2_TEST_CYC(16), .PRES_CYC(PRES), .ABS_CYC(ABS),
    .PW_IDLE_CYC(PWI), .PW_DCHG_CYC(PWD)) cpm_charge_port_i (
    .core_clk(core_clk), .rst(rst), .charge_mode_select_a(code[3]),
    .charge_mode_select_b(code[2]), .charge_mode_select_c(code[1]),
    .limit_choice_pin(code[0]), .port_enable(en),
    .shorted_dev_attach(sda), .data_line_released(rel),
    .curr_over_750ma(o750), .curr_over_lo_plus60(o60),
    .curr_under_lo_plus10(u10), .curr_under_45ma(u45),
    .at_internal_limit(atl), .bc12_primary_det(prim),
    .data_switch_on(sw), .out_discharge(dchg), .bias_scheme(bias),
    .current_limit_sel(lim), .load_present_n(pres_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp());
  cpm_dev_model cpm_dev_model_i (.dev_kind(kind), .load_ma(load),
    .current_limit_sel(lim), .shorted_dev_attach(sda),
    .data_line_released(rel), .curr_over_750ma(o750),
    .curr_over_lo_plus60(o60), .curr_under_lo_plus10(u10),
    .curr_under_45ma(u45), .at_internal_limit(atl),
    .bc12_primary_det(prim));
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  function automatic logic [31:0] pr(input int w);
    case (w)
      0: return {29'h0, bias};
      1: return {30'h0, lim};
      2: return {31'h0, pres_n};
      default: return {31'h0, dchg};
    endcase
  endfunction : pr
  // A wait that runs out ends the run.
  task automatic wt(input int w, input logic [31:0] v, input int n);
    for (int i = 0; i < n && pr(w) !== v; i++) begin
      @(negedge core_clk);
    end
    chk(pr(w), v);
    if (pr(w) !== v) final_report();
  endtask : wt
  task automatic rdy;
    @(posedge core_clk);
    for (int i = 0; i < 20 && hreadyout !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    if (hreadyout !== 1'b1) begin
      err_total++;
      final_report();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask : bus
  task automatic rd(input logic [31:0] a, m, e);
    bus(1'b0, a, 32'h0);
    chk(r & m, e & m);
  endtask : rd
  task automatic pins(input logic [3:0] c, input logic e, input int n);
    @(posedge core_clk);
    code <= c;
    en <= e;
    repeat (n) @(negedge core_clk);
  endtask : pins
  task automatic dev(input logic [1:0] k, input logic [11:0] l, input int n);
    @(posedge core_clk);
    kind <= k;
    load <= l;
    repeat (n) @(negedge core_clk);
  endtask : dev
  // Expected status word.
  function automatic logic [31:0] ex(input logic [3:0] c, input logic e);
    logic [2:0] m;
    logic [1:0] l;
    m = (c == 4'hF) ? 3'h6 : MT[c[3:1]];
    l = (m == 3'h1 || m == 3'h6) ? 2'h1 : {1'b0, c[0]};
    return {18'h0, m == 3'h0, e && (m == 3'h2 || m > 3'h4), 2'h0, l,
            5'h0, m};
  endfunction : ex
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(32'h0, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, 32'h0, 32'h1);
    rd(32'h0, 32'hFFFF_FFFF, 32'h1);
    pins(4'h4, 1'b1, 10);
    rd(32'h4, 32'h7, 32'h0);
    pins(4'h0, 1'b0, 10);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'h8, 32'hFFFF_FFFF);
    rd(32'h8, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, 32'h4, 32'h7);
    rd(32'h4, 32'h2007, 32'h2000);
    for (int k = 0; k < 32; k++) begin
      pins(k[3:0], !k[4], 40);
      rd(32'h4, k[3:1] == 0 ? 32'h3007 : 32'h3307, ex(k[3:0], !k[4]));
    end
    pins(4'h2, 1'b1, 40);
    wt(0, BI_DIV1, 8);
    dev(2'h2, 12'h064, 20);
    chk(pr(0), BI_DIV1);
    dev(2'h1, 12'h064, 0);
    wt(3, 1, 8);
    wt(0, BI_1V2, 20);
    wt(0, BI_SHORT, 20);
    dev(2'h1, 12'h064, 30);
    chk(pr(0), BI_SHORT);
    dev(2'h0, 12'h064, 0);
    wt(0, BI_DIV1, 10);
    dev(2'h0, 12'h384, 0);
    wt(0, BI_DIV2, 10);
    dev(2'h0, 12'h064, 0);
    wt(0, BI_DIV1, 30);
    dev(2'h0, 12'h384, 40);
    chk(pr(0), BI_DIV2);
    dev(2'h0, 12'h064, 0);
    pins(4'h7, 1'b1, 40);
    dev(2'h0, 12'h190, PRES - 4);
    chk(pr(2), 1);
    wt(2, 0, 12);
    dev(2'h0, 12'h000, ABS - 4);
    chk(pr(2), 0);
    wt(2, 1, 12);
    pins(4'hF, 1'b1, 40);
    dev(2'h3, 12'h064, 0);
    wt(2, 0, 8);
    pins(4'hE, 1'b1, 0);
    wt(1, LIM_LO, 8);
    pins(4'hF, 1'b1, 0);
    wt(1, LIM_HI, 8);
    dev(2'h0, 12'h000, 0);
    pins(4'h3, 1'b1, 40);
    chk(pr(1), LIM_HI);
    wt(1, LIM_PW, PWI + 10);
    chk(pr(2), 1);
    dev(2'h0, 12'h0C8, 0);
    wt(2, 0, 8);
    wt(3, 1, 4);
    wt(3, 0, PWD + 10);
    chk(pr(1), LIM_HI);
    final_report();
  end
endmodule : cpm_charge_port_tb
